// ### include/pts_pkg.sv
// shared constants and types of the programmable threshold stage bank
package pts_pkg;
   // ------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------
   localparam int N_STAGES = 10;
   localparam int N_MEAS = 16;
   localparam int MSEL_W = 4;
   localparam int CNT_W = 4;
   localparam int TIME_W = 16;
   localparam int FRAC_BITS = 8;
   localparam logic [7:0] PCT_FULL = 8'h64;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 25000000;
   localparam int TICK_MS = 5;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [11:0] A_CTRL = 12'h000;
   localparam logic [11:0] A_ISTAT = 12'h004;
   localparam logic [11:0] A_IMASK = 12'h008;
   localparam logic [11:0] A_STAGE0 = 12'h100;
   localparam int STRIDE_LOG2 = 5;
   localparam logic [2:0] W_CFG = 3'h0;
   localparam logic [2:0] W_PICK0 = 3'h1;
   localparam logic [2:0] W_PICK1 = 3'h2;
   localparam logic [2:0] W_DELAY = 3'h3;
   localparam logic [2:0] W_SCALE = 3'h4;
   localparam logic [2:0] W_STATE = 3'h5;
   localparam logic [2:0] W_MAG = 3'h6;
   localparam logic [2:0] W_RATIO = 3'h7;
   // ctrl fields
   localparam int C_ACT = 0;
   localparam int C_CNT_LO = 4;
   localparam int C_GRP = 8;
   localparam int C_GSRC = 9;
   localparam int C_AGRP = 12;
   // reset values
   localparam logic [CNT_W-1:0] CNT_RST = 4'h1;
   localparam logic [15:0] MULT_RST = 16'h0100;
   localparam logic [7:0] HYST_RST = 8'h03;
   // ------------------------------------------------------------
   // encodings
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      CRIT_ABOVE = 2'b00,
      CRIT_BELOW = 2'b01,
      CRIT_RATE = 2'b10
   } pts_crit_t;
   typedef enum logic [2:0] {
      COND_NORMAL = 3'b000,
      COND_START = 3'b001,
      COND_TRIP = 3'b010,
      COND_BLOCKED = 3'b011,
      COND_DISABLED = 3'b100
   } pts_cond_t;
   typedef struct packed {
      logic [MSEL_W-1:0] sel2;
      logic [MSEL_W-1:0] sel1;
      logic [MSEL_W-1:0] sel0;
      logic [1:0] nsel;
      pts_crit_t crit;
      logic enable;
   } pts_cfg_t;
   typedef struct packed {
      pts_cond_t cond;
      logic [TIME_W-1:0] remain;
      logic [TIME_W-1:0] expect_t;
      logic signed [31:0] mag;
      logic signed [31:0] ratio;
   } pts_stat_t;
endpackage : pts_pkg

// ### core/pts_tick.sv
// evaluation period tick generator
`timescale 1ns/1ps
module pts_tick #(
   parameter int CYCLES = pts_pkg::TICK_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   output logic tick
);
   import pts_pkg::*;
   logic [31:0] cnt_q, cnt_d;
   always_comb begin
      cnt_d = (cnt_q == 32'(CYCLES - 1)) ? 32'h0 : cnt_q + 32'h1;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 32'h0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
   assign tick = (cnt_q == 32'(CYCLES - 1));
endmodule : pts_tick

// ### core/pts_stage.sv
// one threshold stage: scaling, comparison, hysteresis and delay
`timescale 1ns/1ps
module pts_stage (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tick,
   input wire logic visible,
   input wire pts_pkg::pts_cfg_t cfg,
   input wire logic signed [31:0] pickup,
   input wire logic [pts_pkg::TIME_W-1:0] delay,
   input wire logic signed [15:0] mult,
   input wire logic [7:0] hyst,
   input wire logic signed [31:0] m0,
   input wire logic signed [31:0] m1,
   input wire logic signed [31:0] m2,
   input wire logic blk,
   output pts_pkg::pts_stat_t stat,
   output logic trip,
   output logic start
);
   import pts_pkg::*;
   typedef enum logic [1:0] {
      S_NORMAL = 2'b00,
      S_START = 2'b01,
      S_TRIP = 2'b10,
      S_BLOCKED = 2'b11
   } pts_st_t;
   function automatic logic signed [31:0] scale(input logic signed [31:0] v, input logic signed [15:0] k);
      logic signed [47:0] p;
      p = v * k;
      scale = p[FRAC_BITS+31:FRAC_BITS];
   endfunction : scale
   pts_st_t st_q, st_d;
   logic [TIME_W-1:0] rem_q, rem_d;
   logic signed [31:0] prev_q, prev_d, mag_q, mag_d, rat_q, rat_d;
   logic signed [31:0] s0, s1, s2, calc, hd, lim;
   logic signed [47:0] quo;
   logic run, pick, hold;
   always_comb begin
      s0 = scale(m0, mult);
      s1 = (cfg.nsel >= 2'd2) ? scale(m1, mult) : s0;
      s2 = (cfg.nsel == 2'd3) ? scale(m2, mult) : s0;
      calc = s0;
      case (cfg.crit)
         CRIT_ABOVE: begin
            calc = (s1 > calc) ? s1 : calc;
            calc = (s2 > calc) ? s2 : calc;
         end
         CRIT_BELOW: begin
            calc = (s1 < calc) ? s1 : calc;
            calc = (s2 < calc) ? s2 : calc;
         end
         CRIT_RATE: begin
            calc = (s0 >= prev_q) ? s0 - prev_q : prev_q - s0;
         end
         default: calc = s0;
      endcase
      lim = (pickup < 0) ? -pickup : pickup;
      quo = 48'(lim) * 48'(hyst) / 48'(PCT_FULL);
      hd = quo[31:0];
      if (cfg.crit == CRIT_BELOW) begin
         pick = calc < pickup;
         hold = calc < pickup + hd;
      end else begin
         pick = calc > pickup;
         hold = calc > pickup - hd;
      end
      run = visible && cfg.enable;
      prev_d = tick ? s0 : prev_q;
      mag_d = tick ? calc : mag_q;
      quo = (pickup == 0) ? 48'h0 : (48'(calc) <<< FRAC_BITS) / 48'(pickup);
      rat_d = tick ? quo[31:0] : rat_q;
      st_d = st_q;
      rem_d = rem_q;
      if (!run) begin
         st_d = S_NORMAL;
         rem_d = '0;
      end else if (blk) begin
         st_d = S_BLOCKED;
         rem_d = '0;
      end else if (tick) begin
         case (st_q)
            S_NORMAL, S_BLOCKED: begin
               if (pick && delay == '0) begin
                  st_d = S_TRIP;
               end else if (pick) begin
                  st_d = S_START;
                  rem_d = delay;
               end else begin
                  st_d = S_NORMAL;
               end
            end
            S_START: begin
               if (!hold) begin
                  st_d = S_NORMAL;
                  rem_d = '0;
               end else if (rem_q <= TIME_W'(1)) begin
                  st_d = S_TRIP;
                  rem_d = '0;
               end else begin
                  rem_d = rem_q - TIME_W'(1);
               end
            end
            S_TRIP: begin
               if (!hold) begin
                  st_d = S_NORMAL;
               end
            end
            default: st_d = S_NORMAL;
         endcase
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= S_NORMAL;
         rem_q <= '0;
         prev_q <= '0;
         mag_q <= '0;
         rat_q <= '0;
      end else begin
         st_q <= st_d;
         rem_q <= rem_d;
         prev_q <= prev_d;
         mag_q <= mag_d;
         rat_q <= rat_d;
      end
   end
   always_comb begin
      stat.cond = run ? pts_cond_t'({1'b0, st_q}) : COND_DISABLED;
      stat.remain = run ? rem_q : '0;
      stat.expect_t = run ? delay : '0;
      stat.mag = mag_q;
      stat.ratio = rat_q;
   end
   assign trip = (st_q == S_TRIP);
   assign start = (st_q == S_START);
   a_block_wins: assert property (@(posedge pclk) disable iff (!presetn)
      (run && blk) |=> (st_q == S_BLOCKED)) else $error("blocked stage not blocked");
   a_trip_delay: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(trip) |-> $past(st_q == S_START && rem_q <= TIME_W'(1)) || $past(delay == '0))
      else $error("trip before delay ran out");
   a_drop_reset: assert property (@(posedge pclk) disable iff (!presetn)
      (run && !blk && tick && st_q == S_START && !hold) |=> (st_q == S_NORMAL && rem_q == '0))
      else $error("stage did not drop out");
   a_quiet_off: assert property (@(posedge pclk) disable iff (!presetn)
      !run |=> (!trip && !start)) else $error("idle stage active");
endmodule : pts_stage

// ### core/pts_top.sv
// bank of programmable threshold stages with apb registers and interrupt
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
module pts_top #(
   parameter int TICK_CYC = pts_pkg::TICK_CYCLES,
   parameter int NST = pts_pkg::N_STAGES,
   parameter int NMEAS = pts_pkg::N_MEAS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [NMEAS*32-1:0] meas_in,
   input wire logic [NMEAS-1:0] meas_upd,
   input wire logic group_pin,
   input wire logic [NST-1:0] block_in,
   output logic [NST-1:0] trip_out,
   output logic [NST-1:0] start_out,
   output logic irq
);
   import pts_pkg::*;
   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   typedef struct packed {
      logic is_stage;
      logic [CNT_W-1:0] idx;
      logic [2:0] word;
   } pts_dec_t;
   function automatic pts_dec_t decode(input logic [11:0] a);
      pts_dec_t r;
      logic [11:0] off;
      r.is_stage = (a >= A_STAGE0) && (a < A_STAGE0 + 12'(NST << STRIDE_LOG2)) && (a[1:0] == 2'b00);
      off = a - A_STAGE0;
      r.idx = off[STRIDE_LOG2+CNT_W-1:STRIDE_LOG2];
      r.word = off[4:2];
      decode = r;
   endfunction : decode
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic act_q, act_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic grp_q, grp_d, gsrc_q, gsrc_d;
   logic [2*NST-1:0] ist_q, ist_d, imask_q, imask_d;
   pts_cfg_t cfg_q [NST], cfg_d [NST];
   logic signed [31:0] pk0_q [NST], pk0_d [NST], pk1_q [NST], pk1_d [NST];
   logic [31:0] dly_q [NST], dly_d [NST];
   logic [23:0] sc_q [NST], sc_d [NST];
   logic signed [31:0] meas_q [NMEAS];
   logic [31:0] rd_q, rd_d;
   logic err_q, err_d, irq_q;
   logic tick, agrp, wr, setup;
   pts_dec_t dec;
   pts_stat_t stat [NST];
   logic [NST-1:0] vis, trip_w, start_w, trip_p, start_p;
   // ------------------------------------------------------------
   // evaluation tick
   // ------------------------------------------------------------
   pts_tick #(
      .CYCLES(TICK_CYC)
   ) u_tick (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick)
   );
   // ------------------------------------------------------------
   // measurement capture
   // ------------------------------------------------------------
   genvar gm;
   generate
      for (gm = 0; gm < NMEAS; gm++) begin : g_meas
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               meas_q[gm] <= '0;
            end else if (meas_upd[gm]) begin
               meas_q[gm] <= meas_in[gm*32 +: 32];
            end
         end
         a_meas_take: assert property (@(posedge pclk) disable iff (!presetn)
            meas_upd[gm] |=> (meas_q[gm] == $past(meas_in[gm*32 +: 32])))
            else $error("measurement not captured");
      end
   endgenerate
   // ------------------------------------------------------------
   // apb slave
   // ------------------------------------------------------------
   assign setup = psel && !penable;
   assign wr = psel && penable && pwrite;
   assign dec = decode(paddr);
   assign agrp = gsrc_q ? group_pin : grp_q;
   always_comb begin
      act_d = act_q;
      cnt_d = cnt_q;
      grp_d = grp_q;
      gsrc_d = gsrc_q;
      imask_d = imask_q;
      ist_d = ist_q;
      for (int i = 0; i < NST; i++) begin
         cfg_d[i] = cfg_q[i];
         pk0_d[i] = pk0_q[i];
         pk1_d[i] = pk1_q[i];
         dly_d[i] = dly_q[i];
         sc_d[i] = sc_q[i];
      end
      if (wr && paddr == A_CTRL) begin
         act_d = pwdata[C_ACT];
         if (pwdata[C_CNT_LO +: CNT_W] == '0) begin
            cnt_d = CNT_RST;
         end else if (pwdata[C_CNT_LO +: CNT_W] > CNT_W'(NST)) begin
            cnt_d = CNT_W'(NST);
         end else begin
            cnt_d = pwdata[C_CNT_LO +: CNT_W];
         end
         grp_d = pwdata[C_GRP];
         gsrc_d = pwdata[C_GSRC];
      end
      if (wr && paddr == A_IMASK) begin
         imask_d = pwdata[2*NST-1:0];
      end
      if (wr && paddr == A_ISTAT) begin
         ist_d = ist_q & ~pwdata[2*NST-1:0];
      end
      ist_d = ist_d | {start_p, trip_p};
      if (wr && dec.is_stage && vis[dec.idx]) begin
         case (dec.word)
            W_CFG: cfg_d[dec.idx] = pts_cfg_t'(pwdata[$bits(pts_cfg_t)-1:0]);
            W_PICK0: pk0_d[dec.idx] = pwdata;
            W_PICK1: pk1_d[dec.idx] = pwdata;
            W_DELAY: dly_d[dec.idx] = pwdata;
            W_SCALE: sc_d[dec.idx] = pwdata[23:0];
            default: ;
         endcase
      end
   end
   always_comb begin
      rd_d = rd_q;
      err_d = err_q;
      if (setup) begin
         rd_d = '0;
         err_d = 1'b0;
         if (paddr == A_CTRL) begin
            rd_d[C_ACT] = act_q;
            rd_d[C_CNT_LO +: CNT_W] = cnt_q;
            rd_d[C_GRP] = grp_q;
            rd_d[C_GSRC] = gsrc_q;
            rd_d[C_AGRP] = agrp;
         end else if (paddr == A_ISTAT) begin
            rd_d[2*NST-1:0] = ist_q;
         end else if (paddr == A_IMASK) begin
            rd_d[2*NST-1:0] = imask_q;
         end else if (dec.is_stage && vis[dec.idx]) begin
            case (dec.word)
               W_CFG: rd_d[$bits(pts_cfg_t)-1:0] = cfg_q[dec.idx];
               W_PICK0: rd_d = pk0_q[dec.idx];
               W_PICK1: rd_d = pk1_q[dec.idx];
               W_DELAY: rd_d = dly_q[dec.idx];
               W_SCALE: rd_d[23:0] = sc_q[dec.idx];
               W_STATE: rd_d = {13'h0, stat[dec.idx].cond, stat[dec.idx].remain};
               W_MAG: rd_d = stat[dec.idx].mag;
               W_RATIO: rd_d = stat[dec.idx].ratio;
               default: rd_d = '0;
            endcase
         end else begin
            err_d = 1'b1;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_q <= 1'b0;
         cnt_q <= CNT_RST;
         grp_q <= 1'b0;
         gsrc_q <= 1'b0;
         imask_q <= '0;
         ist_q <= '0;
         rd_q <= '0;
         err_q <= 1'b0;
         irq_q <= 1'b0;
         for (int i = 0; i < NST; i++) begin
            cfg_q[i] <= '0;
            pk0_q[i] <= '0;
            pk1_q[i] <= '0;
            dly_q[i] <= '0;
            sc_q[i] <= {HYST_RST, MULT_RST};
         end
      end else begin
         act_q <= act_d;
         cnt_q <= cnt_d;
         grp_q <= grp_d;
         gsrc_q <= gsrc_d;
         imask_q <= imask_d;
         ist_q <= ist_d;
         rd_q <= rd_d;
         err_q <= err_d;
         irq_q <= |(ist_d & imask_d);
         for (int i = 0; i < NST; i++) begin
            cfg_q[i] <= cfg_d[i];
            pk0_q[i] <= pk0_d[i];
            pk1_q[i] <= pk1_d[i];
            dly_q[i] <= dly_d[i];
            sc_q[i] <= sc_d[i];
         end
      end
   end
   assign pready = 1'b1;
   assign prdata = rd_q;
   assign pslverr = psel && penable && err_q;
   assign irq = irq_q;
   // ------------------------------------------------------------
   // stage bank
   // ------------------------------------------------------------
   logic [NST-1:0] trip_r, start_r;
   genvar gs;
   generate
      for (gs = 0; gs < NST; gs++) begin : g_stage
         assign vis[gs] = act_q && (CNT_W'(gs) < cnt_q);
         pts_stage u_stage (
            .pclk(pclk),
            .presetn(presetn),
            .tick(tick),
            .visible(vis[gs]),
            .cfg(cfg_q[gs]),
            .pickup(agrp ? pk1_q[gs] : pk0_q[gs]),
            .delay(agrp ? dly_q[gs][31:16] : dly_q[gs][15:0]),
            .mult(sc_q[gs][15:0]),
            .hyst(sc_q[gs][23:16]),
            .m0(meas_q[cfg_q[gs].sel0]),
            .m1(meas_q[cfg_q[gs].sel1]),
            .m2(meas_q[cfg_q[gs].sel2]),
            .blk(block_in[gs]),
            .stat(stat[gs]),
            .trip(trip_w[gs]),
            .start(start_w[gs])
         );
         a_hidden_off: assert property (@(posedge pclk) disable iff (!presetn)
            !vis[gs] |=> !trip_w[gs]) else $error("hidden stage tripped");
         a_disabled_code: assert property (@(posedge pclk) disable iff (!presetn)
            (vis[gs] && !cfg_q[gs].enable) |-> (stat[gs].cond == COND_DISABLED))
            else $error("disabled code missing");
      end
   endgenerate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trip_r <= '0;
         start_r <= '0;
      end else begin
         trip_r <= trip_w;
         start_r <= start_w;
      end
   end
   assign trip_p = trip_w & ~trip_r;
   assign start_p = start_w & ~start_r;
   assign trip_out = trip_r;
   assign start_out = start_r;
   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   logic [31:0] gap_q;
   logic seen_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_q <= '0;
         seen_q <= 1'b0;
      end else begin
         gap_q <= tick ? 32'h0 : gap_q + 32'h1;
         seen_q <= seen_q | tick;
      end
   end
   a_tick_period: assert property (@(posedge pclk) disable iff (!presetn)
      (tick && seen_q) |-> (gap_q == 32'(TICK_CYC - 1))) else $error("tick period wrong");
   a_count_range: assert property (@(posedge pclk) disable iff (!presetn)
      (cnt_q >= CNT_RST) && (cnt_q <= CNT_W'(NST))) else $error("stage count out of range");
   a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
      (|trip_p) |=> ((ist_q[NST-1:0] & $past(trip_p)) == $past(trip_p)))
      else $error("trip event lost");
endmodule : pts_top

// ### test/pts_top_tb.sv
// self-checking testbench of the threshold stage bank
`timescale 1ns/1ps
module pts_top_tb;
   import pts_pkg::*;
   localparam int TK = 20;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [N_MEAS*32-1:0] meas_in = '0;
   logic [N_MEAS-1:0] meas_upd = '0;
   logic group_pin = 1'b0;
   logic [N_STAGES-1:0] block_in = '0;
   logic [N_STAGES-1:0] trip_out;
   logic [N_STAGES-1:0] start_out;
   logic irq;
   logic [31:0] rdat;
   logic rerr;
   int err_count = 0;
   int n_checks = 0;
   int cyc = 0;
   int t0;
   int t1;
   // ------------------------------------------------------------
   // design, clock and timeout
   // ------------------------------------------------------------
   pts_top #(.TICK_CYC(TK)) pts_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .meas_in(meas_in), .meas_upd(meas_upd), .group_pin(group_pin), .block_in(block_in),
      .trip_out(trip_out), .start_out(start_out), .irq(irq));
   always #20 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         give_verdict();
      end
   end
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task give_verdict;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : give_verdict
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_checks++;
      if (got !== exp) begin
         $display("wrong value at %0t ns: %s got %h expected %h", $time, m, got, exp);
         err_count++;
      end
   endtask : chk
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] msk, input string m);
      apb(1'b0, a, 32'h0);
      chk(rdat & msk, exp, m);
      chk({31'h0, rerr}, 32'h0, m);
   endtask : rd_chk
   task err_chk(input logic [11:0] a, input string m);
      apb(1'b0, a, 32'h0);
      chk({31'h0, rerr}, 32'h1, m);
      chk(rdat, 32'h0, m);
   endtask : err_chk
   function automatic logic [11:0] sa(input int i, input logic [2:0] w);
      return A_STAGE0 + 12'(i << STRIDE_LOG2) + {7'h0, w, 2'b00};
   endfunction : sa
   task meas(input int ch, input logic [31:0] v);
      meas_in[ch*32 +: 32] <= v;
      meas_upd[ch] <= 1'b1;
      @(posedge pclk);
      meas_upd <= '0;
      @(posedge pclk);
   endtask : meas
   task wait_out(input int idx, input logic trp, input logic lvl, output int t);
      int k;
      for (k = 0; k < 200; k++) begin
         if ((trp ? trip_out[idx] : start_out[idx]) === lvl) break;
         @(posedge pclk);
      end
      t = cyc;
      chk({31'h0, (trp ? trip_out[idx] : start_out[idx])}, {31'h0, lvl}, "stage output");
   endtask : wait_out
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd_chk(A_CTRL, 32'h10, 32'hffffffff, "ctrl reset");
      rd_chk(A_ISTAT, 32'h0, 32'hffffffff, "istat reset");
      rd_chk(A_IMASK, 32'h0, 32'hffffffff, "imask reset");
      err_chk(12'h00c, "unmapped");
      err_chk(sa(0, W_CFG), "inactive stage");
      apb(1'b1, A_CTRL, 32'h01);
      rd_chk(A_CTRL, 32'h11, 32'hffffffff, "count clamp low");
      rd_chk(sa(0, W_SCALE), 32'h00030100, 32'hffffffff, "scale reset");
      rd_chk(sa(0, W_STATE), 32'h00040000, 32'hffffffff, "disabled cond");
      err_chk(sa(1, W_CFG), "hidden stage");
      apb(1'b1, A_CTRL, 32'hf1);
      rd_chk(A_CTRL, 32'ha1, 32'hffffffff, "count clamp high");
      rd_chk(sa(9, W_CFG), 32'h0, 32'hffffffff, "tenth stage");
      apb(1'b1, A_CTRL, 32'h21);
      err_chk(sa(2, W_CFG), "third stage hidden");
      $display("test registers done");
      apb(1'b1, A_IMASK, 32'h3ff);
      apb(1'b1, sa(0, W_PICK0), 32'd100);
      apb(1'b1, sa(0, W_DELAY), 32'd3);
      apb(1'b1, sa(0, W_CFG), 32'h411);
      apb(1'b1, sa(1, W_PICK0), 32'd100);
      apb(1'b1, sa(1, W_CFG), 32'h08);
      meas(0, 32'd200);
      wait_out(0, 1'b0, 1'b1, t0);
      rd_chk(sa(0, W_STATE), 32'h00010003, 32'hffffffff, "started");
      rd_chk(sa(0, W_MAG), 32'd200, 32'hffffffff, "scaled mag");
      rd_chk(sa(0, W_RATIO), 32'h200, 32'hffffffff, "ratio");
      chk({31'h0, irq}, 32'h0, "masked start");
      chk({31'h0, start_out[1]}, 32'h0, "not enabled");
      rd_chk(sa(1, W_STATE), 32'h00040000, 32'h00070000, "cond disabled");
      wait_out(0, 1'b1, 1'b1, t1);
      chk(32'(t1 - t0), 32'(3 * TK), "delay length");
      @(posedge pclk);
      chk({31'h0, irq}, 32'h1, "irq");
      rd_chk(A_ISTAT, 32'h401, 32'hffffffff, "events");
      apb(1'b1, A_ISTAT, 32'h401);
      rd_chk(A_ISTAT, 32'h0, 32'hffffffff, "cleared");
      chk({31'h0, irq}, 32'h0, "irq cleared");
      $display("test above done");
      meas(0, 32'd98);
      repeat (2 * TK) @(posedge pclk);
      chk({31'h0, trip_out[0]}, 32'h1, "hysteresis hold");
      meas(0, 32'd90);
      wait_out(0, 1'b1, 1'b0, t1);
      meas(0, 32'd200);
      wait_out(0, 1'b0, 1'b1, t0);
      meas(0, 32'd50);
      wait_out(0, 1'b0, 1'b0, t0);
      chk({31'h0, trip_out[0]}, 32'h0, "no trip");
      rd_chk(sa(0, W_STATE), 32'h0, 32'hffffffff, "back to normal");
      block_in[0] <= 1'b1;
      meas(0, 32'd200);
      repeat (2 * TK) @(posedge pclk);
      rd_chk(sa(0, W_STATE), 32'h00030000, 32'h00070000, "blocked");
      chk({31'h0, trip_out[0]}, 32'h0, "blocked no trip");
      block_in[0] <= 1'b0;
      meas(0, 32'd50);
      repeat (2 * TK) @(posedge pclk);
      $display("test dropout done");
      apb(1'b1, sa(0, W_DELAY), 32'd0);
      apb(1'b1, sa(0, W_CFG), 32'h0d);
      meas(0, 32'd500);
      wait_out(0, 1'b1, 1'b1, t1);
      apb(1'b1, sa(1, W_PICK1), 32'hffffffce);
      apb(1'b1, sa(1, W_DELAY), 32'd0);
      apb(1'b1, sa(1, W_CFG), 32'h2b);
      meas(1, 32'd0);
      wait_out(1, 1'b1, 1'b1, t1);
      group_pin <= 1'b1;
      apb(1'b1, A_CTRL, 32'h221);
      wait_out(1, 1'b1, 1'b0, t1);
      rd_chk(A_CTRL, 32'h1000, 32'h1000, "group one");
      $display("test modes done");
      give_verdict();
   end
endmodule : pts_top_tb
